/* include/cwf_pkg.sv */
// Package for the CAN wake and fail-safe controller
// Assumes a single 10 MHz clock and synchronous digital inputs from the analog front end
package cwf_pkg;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_HZ = 10000000;
  // Wake filter window, ns: 1.8 us sits below one 500 kbps bit and two 1 Mbps bits
  localparam int WAKE_FILTER_NS = 1800;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS * (CLK_HZ / 1000000)) / 1000;
  // Wake pattern timeout, us
  localparam int WAKE_TIMEOUT_US = 1000;
  localparam int WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * (CLK_HZ / 1000000);
  // Inactivity fallback time, ms
  localparam int INACTIVE_MS = 5;
  localparam int INACTIVE_CYC = INACTIVE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 24;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [2:0] {
    MODE_RESET    = 3'h0,
    MODE_STANDBY  = 3'h1,
    MODE_NORMAL   = 3'h2,
    MODE_SLEEP    = 3'h3,
    MODE_FAILSAFE = 3'h4
  } cwf_mode_t;

  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_DOM1 = 2'h1,
    WK_REC  = 2'h2
  } cwf_wk_t;

  // Fault comparator outputs
  typedef struct packed {
    logic therm_rise;
    logic therm_fall_ok;
    logic ov_rise;
    logic ov_fall_ok;
  } cwf_fault_t;

  // Mode requests from the system controller
  typedef struct packed {
    logic go_normal;
    logic go_standby;
    logic go_sleep;
  } cwf_req_t;

  // State of the controller, apart from the pin synchronisers
  typedef struct packed {
    cwf_mode_t mode;
    cwf_wk_t wk;
    logic bus_prev;
    logic [CNT_W-1:0] phase_cnt;
    logic phase_done;
    logic [CNT_W-1:0] to_cnt;
    logic [CNT_W-1:0] inact_cnt;
    logic wake_prev;
    logic wake_pend;
    logic rxd_low;
    logic remote_wake;
    logic local_wake;
    logic bias_active;
  } cwf_state_t;

endpackage

/* hdl/cwf_ctrl.sv */
// CAN wake detection and protective mode sequencing
// Assumes bus level, fault flags and regulator status are on CLOCK_IN; wake and reset pins are raw
//
// What this block does
// - Bus wake monitor runs in standby and sleep.
// - Pattern is filtered dominant, filtered recessive, filtered dominant, in order.
// - After first dominant, other bus traffic does not return monitor to idle.
// - Second dominant qualified: declare remote wake, drive receive-data low at once.
// - Too-short phases never count; phases longer than filter maximum always count.
// - Filter time short enough for one 500 kbps or two 1 Mbps bits.
// - Pattern must finish within timeout, else monitor resets and device sleeps on.
// - Either edge of wake input raises a local wake request.
// - Local wake detection enabled in sleep mode.
// - Local wake detection disabled in normal mode.
// - Receive-data undriven until the regulator output is present.
// - Reset mode holds system reset low with transmitter and receiver off.
// - Wake monitor active in reset mode; valid pattern biases bus and signals wake.
// - Reset mode entered at power-on and when reset line is pulled low.
// - Leaving fail-safe after faults clear goes to reset mode.
// - Fail-safe turns off regulator, inhibit, transceiver, and holds reset low.
// - Fail-safe entered on thermal or regulator over-voltage rising threshold.
// - Fail-safe exits to reset only with both faults cleared and a wake present.
// - Fail-safe not cleared within inactivity time moves to sleep.
// - In standby receive-data latches low on wake or fault; power-on counts.
// - Sleep exits on remote or local wake to standby, and on reset event to reset.
`timescale 1ns/100ps

module cwf_ctrl #(
  parameter int FILTER_CYC = cwf_pkg::WAKE_FILTER_CYC,
  parameter int TIMEOUT_CYC = cwf_pkg::WAKE_TIMEOUT_CYC,
  parameter int INACTIVE_CYC = cwf_pkg::INACTIVE_CYC
) (
  input wire logic CLOCK_IN,                     // 10 MHz clock
  input wire logic RST_N_IN,                     // Power-on reset, active low
  input wire logic BUS_DOMINANT_IN,              // Low-power receiver, 1 = dominant
  input wire logic WAKE_PIN_IN,                  // Raw local wake pin
  input wire logic SYS_RESET_LOW_IN,             // Reset line readback, low = pulled low
  input wire cwf_pkg::cwf_fault_t FAULT_IN,      // Fault comparators
  input wire cwf_pkg::cwf_req_t REQ_IN,          // Mode requests
  input wire logic REG_PRESENT_IN,               // Regulator output present
  output logic RXD_OUT,                          // Receive-data level
  output logic RXD_OE_OUT,                       // Receive-data drive enable
  output logic SYS_RESET_LOW_OUT,                // Reset drive, low = asserted
  output logic SUPPLY_INHIBIT_OUT,               // Inhibit output on
  output logic REG_ENABLE_OUT,                   // Regulator enable
  output logic XCVR_ON_OUT,                      // Transmitter and receiver on
  output logic BUS_BIAS_ACTIVE_OUT,              // Bus biased to mid supply
  output logic REMOTE_WAKE_OUT,                  // Remote wake pattern seen
  output logic LOCAL_WAKE_OUT,                   // Local wake request seen
  output cwf_pkg::cwf_mode_t MODE_OUT            // Current mode
);

  // Counter end points, one below each cycle count
  localparam logic [cwf_pkg::CNT_W-1:0] FILT_M = cwf_pkg::CNT_W'(FILTER_CYC - 1);
  localparam logic [cwf_pkg::CNT_W-1:0] TO_M = cwf_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [cwf_pkg::CNT_W-1:0] INACT_M = cwf_pkg::CNT_W'(INACTIVE_CYC - 1);
  localparam logic [cwf_pkg::CNT_W-1:0] ONE = cwf_pkg::CNT_W'(1);

  cwf_pkg::cwf_state_t st_r;
  cwf_pkg::cwf_state_t st_nxt;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic wake_s1_r;
  logic wake_s2_r;
  logic rst_s1_r;
  logic rst_s2_r;

  // Two-stage sync of external pins
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
    end else begin
      wake_s1_r <= WAKE_PIN_IN;
      wake_s2_r <= wake_s1_r;
      rst_s1_r <= SYS_RESET_LOW_IN;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ************************************************
  // Next state
  // ************************************************
  // Decoded conditions used by the next-state logic
  logic fault_set;
  logic fault_clear;
  logic mon_on;
  logic local_on;
  logic phase_q;
  logic pattern_hit;
  logic local_hit;
  logic ext_rst;

  // Mode, wake monitor and local wake logic
  always_comb begin
    st_nxt = st_r;
    // Rising thresholds trip fail-safe; falling ones release it
    fault_set = FAULT_IN.therm_rise | FAULT_IN.ov_rise;
    fault_clear = FAULT_IN.therm_fall_ok & FAULT_IN.ov_fall_ok;
    ext_rst = ~rst_s2_r & (st_r.mode != cwf_pkg::MODE_RESET)
      & (st_r.mode != cwf_pkg::MODE_FAILSAFE);
    mon_on = (st_r.mode == cwf_pkg::MODE_STANDBY) | (st_r.mode == cwf_pkg::MODE_SLEEP)
      | (st_r.mode == cwf_pkg::MODE_RESET) | (st_r.mode == cwf_pkg::MODE_FAILSAFE);
    local_on = (st_r.mode != cwf_pkg::MODE_NORMAL);
    pattern_hit = 1'b0;
    local_hit = 1'b0;
    // Phase filter: a level must hold FILTER_CYC + 1 cycles to qualify
    // Count restarts at each level change, so glitches never qualify
    st_nxt.bus_prev = BUS_DOMINANT_IN;
    if (BUS_DOMINANT_IN != st_r.bus_prev) begin
      st_nxt.phase_cnt = '0;
      st_nxt.phase_done = 1'b0;
    end else if (st_r.phase_cnt < FILT_M) begin
      st_nxt.phase_cnt = st_r.phase_cnt + ONE;
    end
    phase_q = (BUS_DOMINANT_IN == st_r.bus_prev) && (st_r.phase_cnt == FILT_M)
      && !st_r.phase_done;
    if (phase_q) begin
      st_nxt.phase_done = 1'b1;
    end
    // Pattern sequencer with whole-pattern timeout
    if (!mon_on) begin
      st_nxt.wk = cwf_pkg::WK_IDLE;
      st_nxt.to_cnt = '0;
    end else begin
      if (st_r.wk != cwf_pkg::WK_IDLE) begin
        st_nxt.to_cnt = st_r.to_cnt + ONE;
      end
      case (st_r.wk)
        cwf_pkg::WK_IDLE: begin
          st_nxt.to_cnt = '0;
          if (phase_q && BUS_DOMINANT_IN) begin
            st_nxt.wk = cwf_pkg::WK_DOM1;
          end
        end
        // Unqualified traffic while waiting leaves the monitor in place
        cwf_pkg::WK_DOM1: begin
          if (phase_q && !BUS_DOMINANT_IN) begin
            st_nxt.wk = cwf_pkg::WK_REC;
          end
        end
        cwf_pkg::WK_REC: begin
          if (phase_q && BUS_DOMINANT_IN) begin
            st_nxt.wk = cwf_pkg::WK_IDLE;
            pattern_hit = 1'b1;
          end
        end
        default: begin
          st_nxt.wk = cwf_pkg::WK_IDLE;
        end
      endcase
      // Timeout window opens at the first qualified dominant
      if (st_r.wk != cwf_pkg::WK_IDLE && st_r.to_cnt >= TO_M && !pattern_hit) begin
        st_nxt.wk = cwf_pkg::WK_IDLE;
        st_nxt.to_cnt = '0;
      end
    end
    // Local wake on either edge of the synced pin
    st_nxt.wake_prev = wake_s2_r;
    if (local_on && (wake_s2_r != st_r.wake_prev)) begin
      local_hit = 1'b1;
    end
    // Inactivity counter runs in standby and fail-safe
    if ((st_r.mode == cwf_pkg::MODE_STANDBY) || (st_r.mode == cwf_pkg::MODE_FAILSAFE)) begin
      if (st_r.inact_cnt < INACT_M) begin
        st_nxt.inact_cnt = st_r.inact_cnt + ONE;
      end
    end else begin
      st_nxt.inact_cnt = '0;
    end
    // Mode sequencing
    case (st_r.mode)
      cwf_pkg::MODE_RESET: begin
        if (rst_s2_r) begin
          st_nxt.mode = cwf_pkg::MODE_STANDBY;
          st_nxt.rxd_low = 1'b1;
        end
      end
      cwf_pkg::MODE_STANDBY: begin
        if (REQ_IN.go_normal) begin
          st_nxt.mode = cwf_pkg::MODE_NORMAL;
          st_nxt.wake_pend = 1'b0;
          st_nxt.rxd_low = 1'b0;
          st_nxt.remote_wake = 1'b0;
          st_nxt.local_wake = 1'b0;
        end else if (REQ_IN.go_sleep || st_r.inact_cnt == INACT_M) begin
          st_nxt.mode = cwf_pkg::MODE_SLEEP;
          st_nxt.bias_active = 1'b0;
        end
      end
      cwf_pkg::MODE_NORMAL: begin
        st_nxt.bias_active = 1'b1;
        if (REQ_IN.go_standby) begin
          st_nxt.mode = cwf_pkg::MODE_STANDBY;
          st_nxt.bias_active = 1'b0;
        end else if (REQ_IN.go_sleep) begin
          st_nxt.mode = cwf_pkg::MODE_SLEEP;
          st_nxt.bias_active = 1'b0;
        end
      end
      cwf_pkg::MODE_SLEEP: begin
        if (pattern_hit | local_hit) begin
          st_nxt.mode = cwf_pkg::MODE_STANDBY;
        end
      end
      cwf_pkg::MODE_FAILSAFE: begin
        if (fault_clear && (st_r.wake_pend || pattern_hit || local_hit)) begin
          st_nxt.mode = cwf_pkg::MODE_RESET;
        end else if (st_r.inact_cnt == INACT_M) begin
          st_nxt.mode = cwf_pkg::MODE_SLEEP;
          st_nxt.wake_pend = 1'b0;
        end
      end
      default: begin
        st_nxt.mode = cwf_pkg::MODE_RESET;
      end
    endcase
    // Wake flags set after the mode logic, so a set beats a clear
    if (pattern_hit) begin
      st_nxt.remote_wake = 1'b1;
      // Bus stays grounded while in fail-safe
      if (st_r.mode != cwf_pkg::MODE_FAILSAFE) begin
        st_nxt.bias_active = 1'b1;
      end
    end
    if (local_hit) begin
      st_nxt.local_wake = 1'b1;
    end
    if (pattern_hit | local_hit) begin
      st_nxt.wake_pend = 1'b1;
      st_nxt.rxd_low = 1'b1;
    end
    // External reset next; a fault overrides it below
    if (ext_rst) begin
      st_nxt.mode = cwf_pkg::MODE_RESET;
      st_nxt.bias_active = 1'b0;
    end
    if (fault_set) begin
      st_nxt.mode = cwf_pkg::MODE_FAILSAFE;
      st_nxt.bias_active = 1'b0;
      if (st_r.mode == cwf_pkg::MODE_STANDBY) begin
        st_nxt.rxd_low = 1'b1;
      end
    end
  end

  // State register; power-on enters reset mode with a pending wake
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= '{mode: cwf_pkg::MODE_RESET, wk: cwf_pkg::WK_IDLE, bus_prev: 1'b0,
        phase_cnt: '0, phase_done: 1'b0, to_cnt: '0, inact_cnt: '0,
        wake_prev: 1'b0, wake_pend: 1'b1, rxd_low: 1'b1, remote_wake: 1'b0,
        local_wake: 1'b0, bias_active: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  // Fail-safe decode shared by the pin drives
  logic fs;
  assign fs = (st_r.mode == cwf_pkg::MODE_FAILSAFE);

  // Pin drives decoded from mode and state flags
  assign RXD_OE_OUT = REG_PRESENT_IN & ~fs;
  assign RXD_OUT = ~st_r.rxd_low;
  assign SYS_RESET_LOW_OUT = ~((st_r.mode == cwf_pkg::MODE_RESET) | fs);
  assign SUPPLY_INHIBIT_OUT = ~fs & (st_r.mode != cwf_pkg::MODE_SLEEP);
  assign REG_ENABLE_OUT = ~fs & (st_r.mode != cwf_pkg::MODE_SLEEP);
  assign XCVR_ON_OUT = (st_r.mode == cwf_pkg::MODE_NORMAL);
  assign BUS_BIAS_ACTIVE_OUT = st_r.bias_active;
  assign REMOTE_WAKE_OUT = st_r.remote_wake;
  assign LOCAL_WAKE_OUT = st_r.local_wake;
  assign MODE_OUT = st_r.mode;

  // ************************************************
  // Checks
  // ************************************************
  // Mode outputs and fail-safe
  a_fault_enters_fs: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (FAULT_IN.therm_rise | FAULT_IN.ov_rise) |=> (MODE_OUT == cwf_pkg::MODE_FAILSAFE))
    else $error("fault did not enter fail-safe");
  a_fs_outputs_off: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    fs |-> (!SUPPLY_INHIBIT_OUT && !REG_ENABLE_OUT && !SYS_RESET_LOW_OUT && !XCVR_ON_OUT))
    else $error("fail-safe outputs not off");
  a_reset_holds_low: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (MODE_OUT == cwf_pkg::MODE_RESET) |-> (!SYS_RESET_LOW_OUT && !XCVR_ON_OUT))
    else $error("reset mode not holding reset low");
  a_fs_exit_reset: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (fs ##1 !fs && !$past(fault_set)) |-> (MODE_OUT == cwf_pkg::MODE_RESET
      || MODE_OUT == cwf_pkg::MODE_SLEEP))
    else $error("fail-safe exited to wrong mode");
  a_fs_exit_cond: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (fs && !fault_clear && !fault_set && st_r.inact_cnt != INACT_M) |=> fs)
    else $error("fail-safe left with fault present");
  a_rxd_needs_reg: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !REG_PRESENT_IN |-> !RXD_OE_OUT)
    else $error("receive-data driven without regulator");
  a_fs_bias_off: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    fs |-> (!BUS_BIAS_ACTIVE_OUT && !RXD_OE_OUT))
    else $error("fail-safe left bus biased or receive-data driven");

  // Wake detection
  a_pattern_rxd_low: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    pattern_hit |=> (REMOTE_WAKE_OUT && !RXD_OUT))
    else $error("wake pattern did not drive receive-data low");
  a_local_off_normal: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (MODE_OUT == cwf_pkg::MODE_NORMAL) |-> !local_hit)
    else $error("local wake in normal mode");
  a_wk_timeout: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (st_r.wk != cwf_pkg::WK_IDLE) |-> (st_r.to_cnt <= TO_M))
    else $error("wake pattern exceeded timeout");
  a_sleep_exit_wake: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    ((MODE_OUT == cwf_pkg::MODE_SLEEP) && local_hit && !fault_set && !ext_rst)
      |=> (MODE_OUT == cwf_pkg::MODE_STANDBY))
    else $error("sleep did not exit on local wake");
  a_local_rxd_low: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    local_hit |=> (LOCAL_WAKE_OUT && !RXD_OUT))
    else $error("local wake did not drive receive-data low");
  a_fault_rxd_low: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (MODE_OUT == cwf_pkg::MODE_STANDBY && fault_set) |=> !RXD_OUT)
    else $error("fault in standby did not latch receive-data low");
  a_pattern_bias: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (pattern_hit && MODE_OUT == cwf_pkg::MODE_RESET && !fault_set) |=> BUS_BIAS_ACTIVE_OUT)
    else $error("wake pattern in reset mode did not bias the bus");

  // Fallbacks and reset entry
  a_fs_sleep_fallback: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (fs && !fault_set && !st_r.wake_pend && !pattern_hit && !local_hit && st_r.inact_cnt == INACT_M)
      |=> (MODE_OUT == cwf_pkg::MODE_SLEEP))
    else $error("fail-safe did not fall back to sleep");
  a_sleep_supply_off: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (MODE_OUT == cwf_pkg::MODE_SLEEP) |-> (!SUPPLY_INHIBIT_OUT && !REG_ENABLE_OUT && !XCVR_ON_OUT))
    else $error("sleep mode not at lowest power");
  a_ext_reset_enters: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (ext_rst && !fault_set) |=> (MODE_OUT == cwf_pkg::MODE_RESET && !BUS_BIAS_ACTIVE_OUT))
    else $error("external reset did not enter reset mode");

endmodule

/* testbench/cwf_bus_node.sv */
// Behavioural CAN bus node sending a list of timed bus phases
// Assumes the controller clock; the bus rests recessive when idle
`timescale 1ns/100ps
module cwf_bus_node (
  input wire logic clk_in,            // Controller clock
  input wire logic rst_n_in,          // Reset, active low
  input wire logic start_in,          // Start a phase list
  input wire logic [47:0] phases_in,  // Phase lengths, low byte first, 0 ends
  output logic bus_dom_out,           // Bus level, 1 = dominant
  output logic busy_out               // Phase list in progress
);
  logic [2:0] idx_r;
  logic [7:0] cnt_r;
  logic [7:0] cur_len;
  // ****************************************
  // Phase sequencing
  // ****************************************
  // Length of the phase now on the bus
  assign cur_len = phases_in[idx_r*8 +: 8];
  // Even phases dominant, odd recessive, idle recessive
  assign bus_dom_out = busy_out & ~idx_r[0];
  // Count cycles of each phase and step through the list
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idx_r <= 3'h0;
      cnt_r <= 8'h00;
      busy_out <= 1'b0;
    end else if (!busy_out) begin
      idx_r <= 3'h0;
      cnt_r <= 8'h00;
      busy_out <= start_in;
    end else if (cnt_r == cur_len - 8'h01) begin
      cnt_r <= 8'h00;
      idx_r <= idx_r + 3'h1;
      if (idx_r == 3'h5 || phases_in[(idx_r+1)*8 +: 8] == 8'h00) begin
        busy_out <= 1'b0;
      end
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

/* testbench/cwf_ctrl_tb.sv */
// Self-checking bench for the wake and fail-safe controller
// Assumes shortened filter, timeout and inactivity counts
`timescale 1ns/100ps
module cwf_ctrl_tb;
  localparam cwf_pkg::cwf_req_t GO_NORMAL = 3'h4;
  localparam cwf_pkg::cwf_req_t GO_SLEEP = 3'h1;
  logic clk, rst_n, wake_pin, sys_rst_in, reg_present, start;
  logic [47:0] phases;
  cwf_pkg::cwf_fault_t fault;
  cwf_pkg::cwf_req_t req;
  logic bus_dom, node_busy, rxd, rxd_oe, sys_rst_out, inhibit, reg_en, xcvr, bias, rwake, lwake;
  cwf_pkg::cwf_mode_t mode;
  int miscompares, compares;
  // ****************************************
  // Design and bus node
  // ****************************************
  cwf_ctrl #(.FILTER_CYC(4), .TIMEOUT_CYC(200), .INACTIVE_CYC(300)) dut_u (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .BUS_DOMINANT_IN(bus_dom), .WAKE_PIN_IN(wake_pin),
    .SYS_RESET_LOW_IN(sys_rst_in), .FAULT_IN(fault), .REQ_IN(req), .REG_PRESENT_IN(reg_present),
    .RXD_OUT(rxd), .RXD_OE_OUT(rxd_oe), .SYS_RESET_LOW_OUT(sys_rst_out), .SUPPLY_INHIBIT_OUT(inhibit),
    .REG_ENABLE_OUT(reg_en), .XCVR_ON_OUT(xcvr), .BUS_BIAS_ACTIVE_OUT(bias),
    .REMOTE_WAKE_OUT(rwake), .LOCAL_WAKE_OUT(lwake), .MODE_OUT(mode));
  cwf_bus_node node_u (.clk_in(clk), .rst_n_in(rst_n), .start_in(start), .phases_in(phases),
    .bus_dom_out(bus_dom), .busy_out(node_busy));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    compares++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic wait_mode(input cwf_pkg::cwf_mode_t m, input int n);
    int i;
    for (i = 0; i < n && mode !== m; i++) cyc(1);
    chk("mode", m, mode);
    if (mode !== m) finish_test();
  endtask
  task automatic pulse_req(input cwf_pkg::cwf_req_t r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= 3'h0;
    #1;
  endtask
  task automatic send(input logic [47:0] p);
    int i;
    @(posedge clk);
    phases <= p;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 1000 && node_busy === 1'b1; i++) cyc(1);
    chk("node_busy", 1'b0, node_busy);
    if (node_busy !== 1'b0) finish_test();
    cyc(3);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_on();
    chk("sys_rst_out", 1'b0, sys_rst_out);
    chk("mode", cwf_pkg::MODE_RESET, mode);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_mode(cwf_pkg::MODE_STANDBY, 6);
    chk("rxd", 1'b0, rxd);
    chk("rxd_oe", 1'b1, rxd_oe);
    @(posedge clk);
    reg_present <= 1'b0;
    #1;
    chk("rxd_oe", 1'b0, rxd_oe);
    @(posedge clk);
    reg_present <= 1'b1;
  endtask
  task automatic t_fail_exit();
    @(posedge clk);
    fault <= 4'h9;
    wait_mode(cwf_pkg::MODE_FAILSAFE, 5);
    chk("reg_en", 1'b0, reg_en);
    chk("inhibit", 1'b0, inhibit);
    chk("sys_rst_out", 1'b0, sys_rst_out);
    chk("xcvr", 1'b0, xcvr);
    chk("rxd_oe", 1'b0, rxd_oe);
    cyc(10);
    @(posedge clk);
    fault <= 4'h1;
    cyc(10);
    chk("mode", cwf_pkg::MODE_FAILSAFE, mode);
    @(posedge clk);
    fault <= 4'h5;
    wait_mode(cwf_pkg::MODE_RESET, 5);
    wait_mode(cwf_pkg::MODE_STANDBY, 6);
  endtask
  task automatic t_normal_local();
    pulse_req(GO_NORMAL);
    wait_mode(cwf_pkg::MODE_NORMAL, 5);
    chk("lwake", 1'b0, lwake);
    @(posedge clk);
    wake_pin <= 1'b1;
    cyc(10);
    chk("lwake", 1'b0, lwake);
    chk("mode", cwf_pkg::MODE_NORMAL, mode);
  endtask
  task automatic t_fail_sleep();
    @(posedge clk);
    fault <= 4'h6;
    wait_mode(cwf_pkg::MODE_FAILSAFE, 5);
    cyc(10);
    @(posedge clk);
    fault <= 4'h5;
    cyc(50);
    chk("mode", cwf_pkg::MODE_FAILSAFE, mode);
    wait_mode(cwf_pkg::MODE_SLEEP, 400);
    chk("inhibit", 1'b0, inhibit);
  endtask
  task automatic t_remote();
    send(48'h000000030303);
    chk("rwake", 1'b0, rwake);
    chk("mode", cwf_pkg::MODE_SLEEP, mode);
    send(48'h00000006FA06);
    cyc(250);
    chk("rwake", 1'b0, rwake);
    chk("mode", cwf_pkg::MODE_SLEEP, mode);
    send(48'h000606020206);
    chk("rwake", 1'b1, rwake);
    chk("rxd", 1'b0, rxd);
    chk("bias", 1'b1, bias);
    chk("mode", cwf_pkg::MODE_STANDBY, mode);
  endtask
  task automatic t_local_edges();
    int i;
    int k;
    for (k = 0; k < 2; k++) begin
      pulse_req(GO_NORMAL);
      wait_mode(cwf_pkg::MODE_NORMAL, 5);
      pulse_req(GO_SLEEP);
      wait_mode(cwf_pkg::MODE_SLEEP, 5);
      @(posedge clk);
      wake_pin <= ~wake_pin;
      for (i = 0; i < 10 && lwake !== 1'b1; i++) cyc(1);
      chk("lwake", 1'b1, lwake);
      if (lwake !== 1'b1) finish_test();
      cyc(3);
      chk("left_sleep", 1'b1, mode !== cwf_pkg::MODE_SLEEP);
    end
  endtask
  task automatic t_ext_reset();
    pulse_req(GO_NORMAL);
    wait_mode(cwf_pkg::MODE_NORMAL, 5);
    @(posedge clk);
    sys_rst_in <= 1'b0;
    wait_mode(cwf_pkg::MODE_RESET, 6);
    chk("sys_rst_out", 1'b0, sys_rst_out);
    chk("xcvr", 1'b0, xcvr);
    chk("bias", 1'b0, bias);
    chk("rwake", 1'b0, rwake);
    send(48'h000000060606);
    chk("rwake", 1'b1, rwake);
    chk("rxd", 1'b0, rxd);
    chk("bias", 1'b1, bias);
    @(posedge clk);
    sys_rst_in <= 1'b1;
    wait_mode(cwf_pkg::MODE_STANDBY, 8);
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    wake_pin = 1'b0;
    sys_rst_in = 1'b1;
    reg_present = 1'b1;
    start = 1'b0;
    phases = 48'h0;
    fault = 4'h5;
    req = 3'h0;
    miscompares = 0;
    compares = 0;
    cyc(2);
    t_power_on();
    t_fail_exit();
    t_normal_local();
    t_fail_sleep();
    t_remote();
    t_local_edges();
    t_ext_reset();
    finish_test();
  end
endmodule
